// >>> rtl/pin4_pwm_pkg.sv
// Package: register map, field layout, reset values and timing of the pin 4 PWM encoder.
// Assumes: registers reached over a 32-bit AXI4-Lite slave, one word per register index.
package pin4_pwm_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_LOW_LEVEL_CFG = 8'h57;
   localparam logic [7:0] IDX_HIGH_LEVEL_CFG = 8'h58;
   localparam logic [7:0] IDX_SPARE_FILLER = 8'h59;
   localparam logic [7:0] IDX_SECTION_ONE_SUM = 8'h7e;
   localparam logic [7:0] IDX_SECTION_TWO_CFG = 8'h80;
   localparam int BYTE_SHIFT = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_LOW_LEVEL_CFG = 16'h007f;
   localparam logic [15:0] RST_HIGH_LEVEL_CFG = 16'h3f80;
   localparam logic [15:0] RST_SPARE_FILLER = 16'h5555;
   localparam logic [15:0] RST_SECTION_ONE_SUM = 16'h0000;
   localparam logic [15:0] RST_SECTION_TWO_CFG = 16'h0000;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int TB_MSB = 15;
   localparam int TB_LSB = 14;
   localparam int HC_MSB = 13;
   localparam int HC_LSB = 7;
   localparam int LC_MSB = 6;
   localparam int LC_LSB = 0;
   localparam int S2_EN_BIT = 15;
   localparam int TCODE_MSB = 2;
   localparam int TCODE_LSB = 0;
   localparam int COUNT_W = 7;
   localparam int TB_CNT_W = 10;

   // ----------------------------------------------------------------
   // Time base lengths minus one, in master-clock periods
   // ----------------------------------------------------------------
   localparam logic [TB_CNT_W-1:0] TB_LEN_00 = 10'h00f;
   localparam logic [TB_CNT_W-1:0] TB_LEN_01 = 10'h03f;
   localparam logic [TB_CNT_W-1:0] TB_LEN_10 = 10'h0ff;
   localparam logic [TB_CNT_W-1:0] TB_LEN_11 = 10'h3ff;

   // ----------------------------------------------------------------
   // AXI responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] tb;
      logic [COUNT_W-1:0] hc;
      logic [COUNT_W-1:0] lc;
   } level_cfg_t;

   typedef enum {PH_STATIC, PH_HIGH, PH_LOW} phase_t;

   // Last value of the time-base counter, i.e. length minus one
   function automatic logic [TB_CNT_W-1:0] tb_last(input logic [1:0] sel);
      case (sel)
         2'h0: tb_last = TB_LEN_00;
         2'h1: tb_last = TB_LEN_01;
         2'h2: tb_last = TB_LEN_10;
         default: tb_last = TB_LEN_11;
      endcase
   endfunction : tb_last

endpackage : pin4_pwm_pkg

// >>> rtl/pin4_pwm_encoder.sv
// Top: AXI4-Lite register file plus the PWM level encoder of pin 4.
// Assumes: LEVEL_IN comes from logic on CLK; CE gates every state change except the reset release.
//
// Functional notes
// R01: Two-bit select gives time base of 16, 64, 256 or 1024 clocks.
// R02: One selected time base drives both generation and encoding of the pin.
// R03: Low-level high count, bits 13:7, sets high units for a logic low.
// R04: Low-level low count, bits 6:0, sets low units for a logic low.
// R05: High-level high count sets high units while conveying a logic high.
// R06: High-level low count sets low units while conveying a logic high.
// R07: Period is sum of counts times time base; each phase its count times it.
// R08: Zero high count on the low level gives a static low.
// R09: Zero low count with nonzero high count on the low level gives static high.
// R10: Both counts zero gives static low, overriding the static high.
// R11: Zero high count on the high level gives a static low.
// R12: Zero low count with nonzero high count on high level gives static high.
// R13: Top two bits of the high-level register read as zero.
// R14: Spare register holds sixteen read/write bits with no effect.
// R15: Sixteen-bit read/write register holds the section one checksum value.
// R16: Bit 15 enables the section two checksum; zero disables it.
// R17: Bits 14:3 of the section two register read as zero.
// R18: Bits 2:0 hold the test converter code, read/write, reset zero.
// R19: Runs continuously; new settings take effect at the next period boundary.
`timescale 1ns/100ps
module pin4_pwm_encoder
   import pin4_pwm_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic LEVEL_IN,
   output logic PWM_OUT,
   output logic PWM_OE,
   output logic SECTION_TWO_SUM_EN,
   output logic [2:0] TEST_CODE,
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);

   initial begin
      if (ADDR_W < 10 || ADDR_W > 16) begin
         $error("ADDR_W must lie between 10 and 16");
      end
   end

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [15:0] low_cfg_q;
   logic [15:0] high_cfg_q;
   logic [15:0] spare_q;
   logic [15:0] sum_one_q;
   logic s2_en_q;
   logic [2:0] tcode_q;

   // ----------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ----------------------------------------------------------------
   logic aw_held_q;
   logic w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [15:0] wdata_q;
   logic [1:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;

   wire aw_take = AWVALID && !aw_held_q && !bvalid_q;
   wire w_take = WVALID && !w_held_q && !bvalid_q;
   wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
   wire [7:0] wr_idx = awaddr_q[BYTE_SHIFT +: 8];
   wire wr_low = wr_fire && wr_idx == IDX_LOW_LEVEL_CFG;
   wire wr_high = wr_fire && wr_idx == IDX_HIGH_LEVEL_CFG;
   wire wr_spare = wr_fire && wr_idx == IDX_SPARE_FILLER;
   wire wr_sum = wr_fire && wr_idx == IDX_SECTION_ONE_SUM;
   wire wr_s2 = wr_fire && wr_idx == IDX_SECTION_TWO_CFG;
   wire wr_hit = wr_low || wr_high || wr_spare || wr_sum || wr_s2;
   wire [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [15:0] wr_val = wdata_q & wmask;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                         input logic [15:0] msk);
      merge = (old & ~msk) | val;
   endfunction : merge

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (CE) begin
         if (aw_take) begin
            aw_held_q <= 1'b1;
            awaddr_q <= AWADDR;
         end
         if (w_take) begin
            w_held_q <= 1'b1;
            wdata_q <= WDATA[15:0];
            wstrb_q <= WSTRB[1:0];
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Reserved bits are never stored, so they cannot read back as ones
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         low_cfg_q <= RST_LOW_LEVEL_CFG;
         high_cfg_q <= RST_HIGH_LEVEL_CFG;
         spare_q <= RST_SPARE_FILLER;
         sum_one_q <= RST_SECTION_ONE_SUM;
         s2_en_q <= RST_SECTION_TWO_CFG[S2_EN_BIT];
         tcode_q <= RST_SECTION_TWO_CFG[TCODE_MSB:TCODE_LSB];
      end else if (CE) begin
         if (wr_low) low_cfg_q <= merge(low_cfg_q, wr_val, wmask); // [R01] [R03] [R04]
         if (wr_high) begin
            high_cfg_q <= merge(high_cfg_q, wr_val, wmask) & 16'h3fff; // [R05] [R06] [R13]
         end
         if (wr_spare) spare_q <= merge(spare_q, wr_val, wmask); // [R14]
         if (wr_sum) sum_one_q <= merge(sum_one_q, wr_val, wmask); // [R15]
         if (wr_s2 && wstrb_q[1]) s2_en_q <= wdata_q[S2_EN_BIT]; // [R16]
         if (wr_s2 && wstrb_q[0]) tcode_q <= wdata_q[TCODE_MSB:TCODE_LSB]; // [R18]
      end
   end

   // ----------------------------------------------------------------
   // Read channel: answer one cycle after the address is taken
   // ----------------------------------------------------------------
   logic rvalid_q;
   logic arready_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // Ready is a flop so the address is only taken at a true handshake edge
   wire ar_take = ARVALID && arready_q;
   wire [7:0] rd_idx = ARADDR[BYTE_SHIFT +: 8];
   wire rd_low = rd_idx == IDX_LOW_LEVEL_CFG;
   wire rd_high = rd_idx == IDX_HIGH_LEVEL_CFG;
   wire rd_spare = rd_idx == IDX_SPARE_FILLER;
   wire rd_sum = rd_idx == IDX_SECTION_ONE_SUM;
   wire rd_s2 = rd_idx == IDX_SECTION_TWO_CFG;
   wire rd_hit = rd_low || rd_high || rd_spare || rd_sum || rd_s2;
   wire [15:0] s2_word = {s2_en_q, 12'h000, tcode_q}; // [R17]
   wire [15:0] rd_word = ({16{rd_low}} & low_cfg_q)
                       | ({16{rd_high}} & {2'h0, high_cfg_q[13:0]}) // [R13]
                       | ({16{rd_spare}} & spare_q)
                       | ({16{rd_sum}} & sum_one_q)
                       | ({16{rd_s2}} & s2_word);

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (CE) begin
         if (ar_take) begin
            rvalid_q <= 1'b1;
            arready_q <= 1'b0;
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_q && RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end else if (!rvalid_q) begin
            arready_q <= 1'b1;
         end
      end
   end

   assign AWREADY = aw_held_q;
   assign WREADY = w_held_q;

   // ----------------------------------------------------------------
   // PWM generator
   // ----------------------------------------------------------------
   level_cfg_t low_lvl;
   level_cfg_t high_lvl;
   level_cfg_t sel_cfg;
   phase_t phase_q;
   logic [TB_CNT_W-1:0] tb_cnt_q;
   logic [TB_CNT_W-1:0] tb_last_q;
   logic [COUNT_W-1:0] unit_q;
   logic [COUNT_W-1:0] hc_q;
   logic [COUNT_W-1:0] lc_q;
   logic pwm_q;

   // Both levels share one time base field
   assign low_lvl = '{tb: low_cfg_q[TB_MSB:TB_LSB], hc: low_cfg_q[HC_MSB:HC_LSB],
                      lc: low_cfg_q[LC_MSB:LC_LSB]};
   assign high_lvl = '{tb: low_cfg_q[TB_MSB:TB_LSB], hc: high_cfg_q[HC_MSB:HC_LSB],
                       lc: high_cfg_q[LC_MSB:LC_LSB]}; // [R02]
   assign sel_cfg = LEVEL_IN ? high_lvl : low_lvl;

   wire unit_tick = CE && tb_cnt_q == tb_last_q; // [R01]
   wire high_done = phase_q == PH_HIGH && unit_q == hc_q - 7'h01;
   wire low_done = phase_q == PH_LOW && unit_q == lc_q - 7'h01;
   // A static level re-evaluates every unit so a change shows within one unit
   wire boundary = unit_tick && (phase_q == PH_STATIC || low_done
                   || (high_done && lc_q == 7'h00)); // [R19]
   wire sel_zero_hc = sel_cfg.hc == 7'h00;
   wire sel_zero_lc = sel_cfg.lc == 7'h00;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         tb_cnt_q <= '0;
         tb_last_q <= TB_LEN_00;
      end else if (CE) begin
         if (unit_tick) begin
            tb_cnt_q <= '0;
            if (boundary) tb_last_q <= tb_last(sel_cfg.tb); // [R01] [R19]
         end else begin
            tb_cnt_q <= tb_cnt_q + 10'h001;
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= PH_STATIC;
         unit_q <= '0;
         hc_q <= '0;
         lc_q <= '0;
         pwm_q <= 1'b0;
      end else if (CE && unit_tick) begin
         if (boundary) begin
            hc_q <= sel_cfg.hc;
            lc_q <= sel_cfg.lc;
            unit_q <= '0;
            if (sel_zero_hc) begin
               phase_q <= PH_STATIC; // [R08] [R10] [R11]
               pwm_q <= 1'b0;
            end else if (sel_zero_lc) begin
               phase_q <= PH_STATIC; // [R09] [R12]
               pwm_q <= 1'b1;
            end else begin
               phase_q <= PH_HIGH; // [R03] [R05] [R07]
               pwm_q <= 1'b1;
            end
         end else begin
            case (phase_q)
               PH_HIGH: begin
                  if (high_done) begin
                     phase_q <= PH_LOW; // [R04] [R06] [R07]
                     unit_q <= '0;
                     pwm_q <= 1'b0;
                  end else begin
                     unit_q <= unit_q + 7'h01;
                  end
               end
               PH_LOW: unit_q <= unit_q + 7'h01;
               default: unit_q <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic oe_q;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) oe_q <= 1'b0;
      else if (CE) oe_q <= 1'b1;
   end

   assign PWM_OUT = pwm_q;
   assign PWM_OE = oe_q;
   assign SECTION_TWO_SUM_EN = s2_en_q;
   assign TEST_CODE = tcode_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   assign ARREADY = arready_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence reload_s(logic lvl, logic cond);
      boundary && LEVEL_IN == lvl && cond;
   endsequence

   AST_TB_RESTART: assert property (@(posedge CLK) disable iff (!rst_n) // [R01]
      unit_tick |=> tb_cnt_q == 10'h000 && tb_last_q <= TB_LEN_11)
      else $error("time base counter did not restart");
   AST_LL_STATIC_LOW: assert property (@(posedge CLK) disable iff (!rst_n) // [R08]
      reload_s(1'b0, sel_zero_hc) |=> !pwm_q && phase_q == PH_STATIC)
      else $error("low level with zero high count not static low");
   AST_LL_STATIC_HIGH: assert property (@(posedge CLK) disable iff (!rst_n) // [R09]
      reload_s(1'b0, !sel_zero_hc && sel_zero_lc) |=> pwm_q && phase_q == PH_STATIC)
      else $error("low level with zero low count not static high");
   AST_BOTH_ZERO_LOW: assert property (@(posedge CLK) disable iff (!rst_n) // [R10]
      boundary && sel_zero_hc && sel_zero_lc |=> !pwm_q)
      else $error("both counts zero did not give low");
   AST_LH_STATIC_LOW: assert property (@(posedge CLK) disable iff (!rst_n) // [R11]
      reload_s(1'b1, sel_zero_hc) |=> !pwm_q)
      else $error("high level with zero high count not static low");
   AST_LH_STATIC_HIGH: assert property (@(posedge CLK) disable iff (!rst_n) // [R12]
      reload_s(1'b1, !sel_zero_hc && sel_zero_lc) |=> pwm_q)
      else $error("high level with zero low count not static high");
   AST_HIGH_TO_LOW: assert property (@(posedge CLK) disable iff (!rst_n) // [R07]
      unit_tick && high_done && lc_q != 7'h00 |=> !pwm_q && phase_q == PH_LOW)
      else $error("high phase did not end after its count");
   AST_WAVE_START: assert property (@(posedge CLK) disable iff (!rst_n) // [R03]
      boundary && !sel_zero_hc && !sel_zero_lc |=> pwm_q && hc_q == $past(sel_cfg.hc))
      else $error("period did not start high with the new count");
   AST_RSVD_HIGH: assert property (@(posedge CLK) disable iff (!rst_n) // [R13]
      CE && ar_take && rd_high |=> RDATA[15:14] == 2'h0)
      else $error("reserved bits of high level register not zero");
   AST_RSVD_S2: assert property (@(posedge CLK) disable iff (!rst_n) // [R17]
      CE && ar_take && rd_s2 |=> RDATA[14:3] == 12'h000 && RDATA[2:0] == $past(tcode_q))
      else $error("section two register read wrong");
   AST_S2_WRITE: assert property (@(posedge CLK) disable iff (!rst_n) // [R16]
      CE && wr_s2 && wstrb_q[1] |=> s2_en_q == $past(wdata_q[S2_EN_BIT]))
      else $error("checksum enable not written");

endmodule : pin4_pwm_encoder

// >>> test/pwm_level_receiver.sv
// Receiver model: measures the run lengths of the PWM-coded pin.
// Assumes: line sampled on the same clock as the encoder; clear is a one-cycle pulse.
`timescale 1ns/100ps
module pwm_level_receiver (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic line,
   output int high_len,
   output int low_len,
   output int edges
);
   int run_q;
   logic prev_q;

   // ----------------------------------------------------------------
   // Run-length decoding
   // ----------------------------------------------------------------
   // First run after a clear is partial, so callers need three or more edges
   always @(posedge clk) begin
      if (!rst_n || clear) begin
         run_q <= 1;
         edges <= 0;
         high_len <= 0;
         low_len <= 0;
         prev_q <= line;
      end else if (line !== prev_q) begin
         if (prev_q) begin
            high_len <= run_q;
         end else begin
            low_len <= run_q;
         end
         run_q <= 1;
         edges <= edges + 1;
         prev_q <= line;
      end else begin
         run_q <= run_q + 1;
      end
   end
endmodule : pwm_level_receiver

// >>> test/tb_gpio_level_pwm_encoder.sv
// Testbench: register access over AXI4-Lite and PWM timing checks of pin 4.
// Assumes: encoder package compiled first; receiver model alongside.
`timescale 1ns/100ps
module tb_gpio_level_pwm_encoder;
   import pin4_pwm_pkg::*;
   logic CLK, RST_N, CE, LEVEL_IN, PWM_OUT, PWM_OE, SECTION_TWO_SUM_EN;
   logic [2:0] TEST_CODE;
   logic [9:0] AWADDR, ARADDR;
   logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   logic clear_rx;
   int high_len, low_len, edges, err_total, samples_checked, last_per;
   localparam int TB_UNIT[4] = '{16, 64, 256, 1024};

   pin4_pwm_encoder #(.ADDR_W(10)) i_pin4_pwm_encoder (.CLK(CLK), .RST_N(RST_N), .CE(CE),
      .LEVEL_IN(LEVEL_IN), .PWM_OUT(PWM_OUT), .PWM_OE(PWM_OE),
      .SECTION_TWO_SUM_EN(SECTION_TWO_SUM_EN), .TEST_CODE(TEST_CODE), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
      .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
      .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY));
   pwm_level_receiver i_pwm_level_receiver (.clk(CLK), .rst_n(RST_N), .clear(clear_rx),
      .line(PWM_OUT), .high_len(high_len), .low_len(low_len), .edges(edges));

   // ----------------------------------------------------------------
   // Clock, checks and closing
   // ----------------------------------------------------------------
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : check

   task automatic results();
      $display("mismatches %0d of %0d checks", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   // Ready stays high between calls; only the watchdog ends a wait
   task automatic reg_write(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
      AWADDR <= {idx, 2'b00};
      WDATA <= {16'h0, d};
      WSTRB <= 4'h3;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge CLK);
         if (AWVALID && AWREADY) AWVALID <= 1'b0;
         if (WVALID && WREADY) WVALID <= 1'b0;
      end while (!BVALID);
      check("write response", {30'h0, er}, {30'h0, BRESP});
   endtask : reg_write

   task automatic reg_read(input logic [7:0] idx, input logic [15:0] ed, input logic [1:0] er);
      ARADDR <= {idx, 2'b00};
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge CLK);
         if (ARVALID && ARREADY) ARVALID <= 1'b0;
      end while (!RVALID);
      check("read data", {16'h0, ed}, RDATA);
      check("read response", {30'h0, er}, {30'h0, RRESP});
   endtask : reg_read

   // ----------------------------------------------------------------
   // PWM case: active level gets hc/lc, the other level a decoy setting
   // ----------------------------------------------------------------
   task automatic pwm_case(input logic [1:0] tb, input logic lvl, input logic [6:0] hc,
                           input logic [6:0] lc);
      int unit;
      int per;
      unit = TB_UNIT[tb];
      per = (hc == 0 || lc == 0) ? unit : (hc + lc) * unit;
      reg_write(IDX_HIGH_LEVEL_CFG, lvl ? {2'b00, hc, lc} : 16'h0285, RESP_OKAY);
      reg_write(IDX_LOW_LEVEL_CFG, lvl ? {tb, 14'h0285} : {tb, hc, lc}, RESP_OKAY);
      LEVEL_IN <= lvl;
      repeat (2 * last_per + 2 * per + 64) @(posedge CLK);
      clear_rx <= 1'b1;
      @(posedge CLK);
      clear_rx <= 1'b0;
      repeat (2 * per + 2 * unit) @(posedge CLK);
      if (hc == 0 || lc == 0) begin
         check("static edges", 0, edges);
         check("static level", {31'h0, hc != 0}, {31'h0, PWM_OUT});
      end else begin
         check("high time", hc * unit, high_len);
         check("low time", lc * unit, low_len);
      end
      last_per = per;
   endtask : pwm_case

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int c;
      RST_N = 1'b0;
      CE = 1'b1;
      LEVEL_IN = 1'b0;
      AWADDR = '0;
      ARADDR = '0;
      WDATA = '0;
      WSTRB = '0;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY, clear_rx} = '0;
      err_total = 0;
      samples_checked = 0;
      last_per = 2048;
      repeat (12) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (5) @(posedge CLK);
      check("pin enable", 1, {31'h0, PWM_OE});
      reg_read(IDX_LOW_LEVEL_CFG, RST_LOW_LEVEL_CFG, RESP_OKAY);
      reg_read(IDX_HIGH_LEVEL_CFG, RST_HIGH_LEVEL_CFG, RESP_OKAY);
      reg_read(IDX_SPARE_FILLER, RST_SPARE_FILLER, RESP_OKAY);
      reg_read(IDX_SECTION_ONE_SUM, RST_SECTION_ONE_SUM, RESP_OKAY);
      reg_read(IDX_SECTION_TWO_CFG, RST_SECTION_TWO_CFG, RESP_OKAY);
      reg_write(8'h5a, 16'hffff, RESP_SLVERR);
      reg_read(8'h5a, 16'h0000, RESP_SLVERR);
      reg_write(IDX_HIGH_LEVEL_CFG, 16'hffff, RESP_OKAY);
      reg_read(IDX_HIGH_LEVEL_CFG, 16'h3fff, RESP_OKAY);
      reg_write(IDX_SPARE_FILLER, 16'ha5c3, RESP_OKAY);
      reg_read(IDX_SPARE_FILLER, 16'ha5c3, RESP_OKAY);
      reg_write(IDX_SECTION_ONE_SUM, 16'h1234, RESP_OKAY);
      reg_read(IDX_SECTION_ONE_SUM, 16'h1234, RESP_OKAY);
      reg_write(IDX_SECTION_TWO_CFG, 16'hffff, RESP_OKAY);
      reg_read(IDX_SECTION_TWO_CFG, 16'h8007, RESP_OKAY);
      check("checksum enable", 1, {31'h0, SECTION_TWO_SUM_EN});
      for (c = 0; c < 8; c++) begin
         reg_write(IDX_SECTION_TWO_CFG, {13'h0, c[2:0]}, RESP_OKAY);
         @(posedge CLK);
         check("test code", c, {29'h0, TEST_CODE});
         check("checksum disable", 0, {31'h0, SECTION_TWO_SUM_EN});
      end
      // Periodic cases across all four time bases, alternating conveyed level
      pwm_case(2'h0, 1'b0, 7'd3, 7'd2);
      pwm_case(2'h1, 1'b1, 7'd2, 7'd1);
      pwm_case(2'h2, 1'b0, 7'd1, 7'd2);
      pwm_case(2'h3, 1'b1, 7'd1, 7'd1);
      // Static outcomes of zero counts
      pwm_case(2'h0, 1'b0, 7'd0, 7'd5);
      pwm_case(2'h0, 1'b0, 7'd4, 7'd0);
      pwm_case(2'h0, 1'b0, 7'd0, 7'd0);
      pwm_case(2'h0, 1'b1, 7'd0, 7'd6);
      pwm_case(2'h0, 1'b1, 7'd3, 7'd0);
      pwm_case(2'h0, 1'b1, 7'd0, 7'd0);
      results();
   end

   // Hang guard, about twice the expected run length
   initial begin
      repeat (60000) @(posedge CLK);
      err_total++;
      results();
   end
endmodule : tb_gpio_level_pwm_encoder
